// ==== bpf_map.svh ====
// Offsets, field layouts, reset values and constants of the packet framer
`ifndef BPF_MAP_SVH
`define BPF_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BPF_A_CTRL 8'h00
`define BPF_A_GROUPS 8'h04
`define BPF_A_STATUS 8'h08
`define BPF_A_NCOUNT 8'h0C
`define BPF_A_CRC 8'h10
`define BPF_FLD_PAGE 3'h1
`define BPF_FLD_SLOTS 3'h7

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BPF_CTRL_START 0
`define BPF_RST_GROUPS 7'h00
`define BPF_RST_FMASK 30'h0000_0000
`define BPF_RST_N 8'h00

// ----------------------------------------
// Packet constants
// ----------------------------------------
`define BPF_SYNC_BYTE 8'hFA
`define BPF_SEL_MORE 1'h0
`define BPF_WORD_BITS 15
`define BPF_NONE_GRP 3'h7
`define BPF_NONE_FLD 5'h1E
`define BPF_VAR_GRP_A 3'h3
`define BPF_VAR_GRP_B 3'h6
`define BPF_VAR_FLD_A 5'h0E
`define BPF_VAR_FLD_B 5'h0F
`define BPF_FIX_FLDS 5'h10
`define BPF_VAR_A_BASE 13'h0002
`define BPF_VAR_A_STEP 13'h0008
`define BPF_VAR_B_BASE 13'h000C
`define BPF_VAR_B_STEP 13'h001C

// ----------------------------------------
// Checksum
// ----------------------------------------
`define BPF_CRC_INIT 16'h0000
`define BPF_CRC_POLY 16'h1021

`endif

// ==== bpf_pkg.sv ====
// Types shared by the packet framer modules
package bpf_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_SYNC,
        S_GRP,
        S_FW_LO,
        S_FW_HI,
        S_PAY_NEXT,
        S_PAY_REQ,
        S_PAY_WAIT,
        S_PAY_SEND,
        S_CRC_HI,
        S_CRC_LO
    } bpf_state_type;

endpackage : bpf_pkg

// ==== bpf_crc_if.sv ====
// Checksum engine connection between framer and engine
`timescale 1ns/10ps
interface bpf_crc_if;
    logic clr;
    logic en;
    logic [7:0] data;
    logic [15:0] crc;

    modport client (output clr, output en, output data, input crc);
    modport engine (input clr, input en, input data, output crc);
endinterface : bpf_crc_if

// ==== bpf_crc16.sv ====
// Running 16-bit checksum over the bytes fed to it
`timescale 1ns/10ps
`include "bpf_map.svh"
module bpf_crc16
    import bpf_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    bpf_crc_if.engine crc_bus
);

    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;

    // ----------------------------------------
    // Byte update, most significant bit first
    // ----------------------------------------
    always_comb begin
        nxt_crc = crc_ff ^ {crc_bus.data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (nxt_crc[15]) begin
                nxt_crc = {nxt_crc[14:0], 1'b0} ^ `BPF_CRC_POLY;
            end else begin
                nxt_crc = {nxt_crc[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || crc_bus.clr) begin
            crc_ff <= `BPF_CRC_INIT;
        end else if (crc_bus.en) begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc_bus.crc = crc_ff;

endmodule : bpf_crc16

// ==== bpf_framer.sv ====
// Binary output packet framer: header, payload requests and checksum
// What the document requires
// [RULE1] Packet opens with one sync byte
// [RULE2] Group byte: bits 0-6 groups, bit7 continuation
// [RULE3] Field words: 15 enables plus continuation bit
// [RULE4] Continuation set means another word follows
// [RULE5] Second word enables fields 16 to 30
// [RULE6] Group word sequences in ascending group order
// [RULE7] One word sequence per enabled group
// [RULE8] Payload groups in ascending order
// [RULE9] Fields packed with no filler bytes
// [RULE10] Checksum covers group byte through payload
// [RULE11] Appended checksum leaves zero residue
// [RULE12] Receiver rejects nonzero checksum residue
// [RULE13] Payload length derived from fixed field sizes
// [RULE14] Group 1 field sizes table
// [RULE15] Groups 2,3,5,6 field sizes tables
// [RULE16] Groups 4 and 7 share sizes
// [RULE17] Variable fields sized from entry count
// [RULE18] Multi-byte values least significant byte first; the checksum goes out high byte first
// [RULE19] Fields within group in ascending order
// [RULE20] Receiver resynchronises on sync byte
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "bpf_map.svh"
module bpf_framer
    import bpf_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [7:0] o_tx_byte,
    output logic o_tx_valid,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    output logic o_pl_req,
    output logic [2:0] o_pl_group,
    output logic [4:0] o_pl_field,
    output logic [12:0] o_pl_index,
    input wire logic i_pl_valid,
    input wire logic [7:0] i_pl_byte,
    output logic o_busy
);

    // ----------------------------------------
    // Field size table, zero marks absent
    // ----------------------------------------
    // [RULE14] group 1 sizes
    // [RULE15] groups 2,3,5,6 sizes
    // [RULE16] groups 4,7 shared sizes
    localparam logic [5:0] SZ_TAB [0:6][0:15] = '{
        '{6'h08, 6'h08, 6'h08, 6'h0C, 6'h10, 6'h0C, 6'h18, 6'h0C,
          6'h0C, 6'h18, 6'h14, 6'h1C, 6'h02, 6'h04, 6'h08, 6'h00},
        '{6'h08, 6'h08, 6'h08, 6'h02, 6'h08, 6'h08, 6'h08, 6'h04,
          6'h04, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h02, 6'h0C, 6'h0C, 6'h0C, 6'h04, 6'h04, 6'h10, 6'h0C,
          6'h0C, 6'h0C, 6'h0C, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h08, 6'h08, 6'h02, 6'h01, 6'h01, 6'h18, 6'h18, 6'h0C,
          6'h0C, 6'h0C, 6'h04, 6'h04, 6'h02, 6'h1C, 6'h00, 6'h00},
        '{6'h02, 6'h0C, 6'h10, 6'h24, 6'h0C, 6'h0C, 6'h0C, 6'h0C,
          6'h0C, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h02, 6'h18, 6'h18, 6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h0C,
          6'h0C, 6'h04, 6'h04, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h08, 6'h08, 6'h02, 6'h01, 6'h01, 6'h18, 6'h18, 6'h0C,
          6'h0C, 6'h0C, 6'h04, 6'h04, 6'h02, 6'h1C, 6'h00, 6'h00}
    };

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic [12:0] fsize(input logic [2:0] g,
                                          input logic [4:0] f,
                                          input logic [7:0] n);
        logic [12:0] s;
        logic var_grp;
        s = '0;
        var_grp = (g == `BPF_VAR_GRP_A) || (g == `BPF_VAR_GRP_B);
        if (g != `BPF_NONE_GRP && f < `BPF_FIX_FLDS) begin
            s = {7'h00, SZ_TAB[g][f[3:0]]};
            // [RULE17] variable length fields
            if (var_grp && f == `BPF_VAR_FLD_A) begin
                s = 13'(`BPF_VAR_A_BASE + 13'(n) * `BPF_VAR_A_STEP);
            end
            if (var_grp && f == `BPF_VAR_FLD_B) begin
                s = 13'(`BPF_VAR_B_BASE + 13'(n) * `BPF_VAR_B_STEP);
            end
        end
        return s;
    endfunction : fsize

    function automatic logic [29:0] eff_mask(input logic [2:0] g,
                                             input logic [29:0] raw);
        logic [29:0] m;
        m = '0;
        for (int i = 0; i < 30; i++) begin
            m[i] = raw[i] && (fsize(g, 5'(i), `BPF_RST_N) != '0);
        end
        return m;
    endfunction : eff_mask

    function automatic logic [2:0] next_grp(input logic [6:0] en,
                                            input logic [3:0] from);
        logic [2:0] r;
        r = `BPF_NONE_GRP;
        for (int i = 6; i >= 0; i--) begin
            if (4'(i) >= from && en[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : next_grp

    function automatic logic [4:0] next_fld(input logic [29:0] m,
                                            input logic [4:0] from);
        logic [4:0] r;
        r = `BPF_NONE_FLD;
        for (int i = 29; i >= 0; i--) begin
            if (5'(i) >= from && m[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : next_fld

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    bpf_state_type state_ff;
    logic [6:0] groups_ff;
    logic [29:0] fmask_ff [0:6];
    logic [7:0] n_a_ff;
    logic [7:0] n_b_ff;
    logic [15:0] pkt_cnt_ff;
    logic [15:0] last_crc_ff;
    logic [2:0] grp_ff;
    logic word_ff;
    logic [4:0] fld_ff;
    logic [4:0] from_ff;
    logic [12:0] size_ff;
    logic [12:0] idx_ff;
    logic [7:0] pay_byte_ff;
    logic [31:0] rdata_ff;
    logic [7:0] tx_byte_ff;
    logic tx_valid_ff;
    logic tx_last_ff;
    logic pl_req_ff;
    logic busy_ff;

    bpf_crc_if crc_bus ();

    bpf_crc16 u_crc (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .crc_bus(crc_bus)
    );

    // ----------------------------------------
    // Decode and selection
    // ----------------------------------------
    wire fld_hit = (i_addr[7:5] == `BPF_FLD_PAGE) && (i_addr[1:0] == 2'h0)
        && (i_addr[4:2] != `BPF_FLD_SLOTS);
    wire [2:0] fld_slot = i_addr[4:2];
    wire start_req = i_wr && (i_addr == `BPF_A_CTRL)
        && i_wdata[`BPF_CTRL_START] && (state_ff == S_IDLE);
    wire tx_free = !tx_valid_ff || i_tx_ready;
    wire [7:0] cur_n = (grp_ff == `BPF_VAR_GRP_B) ? n_b_ff : n_a_ff;
    wire [29:0] cur_raw = (grp_ff == `BPF_NONE_GRP) ? 30'h0 : fmask_ff[grp_ff];
    // [RULE13] header and payload share the masked selection
    wire [29:0] cur_mask = eff_mask(grp_ff, cur_raw);
    // [RULE4] continuation when upper fields selected
    wire more_words = |cur_mask[29:`BPF_WORD_BITS];
    // [RULE3] enable bits below, continuation on top
    // [RULE5] second word carries fields 16 to 30
    wire [15:0] sel_word = word_ff
        ? {1'b0, cur_mask[29:`BPF_WORD_BITS]}
        : {more_words, cur_mask[`BPF_WORD_BITS-1:0]};
    wire [2:0] grp_after = next_grp(groups_ff, {1'b0, grp_ff} + 4'h1);
    wire [2:0] grp_first = next_grp(groups_ff, 4'h0);
    // [RULE19] lowest remaining field first
    wire [4:0] fld_next = next_fld(cur_mask, from_ff);
    wire [12:0] idx_inc = idx_ff + 13'h0001;
    wire emit_state = (state_ff == S_SYNC) || (state_ff == S_GRP)
        || (state_ff == S_FW_LO) || (state_ff == S_FW_HI)
        || (state_ff == S_PAY_SEND) || (state_ff == S_CRC_HI)
        || (state_ff == S_CRC_LO);
    wire emit = emit_state && tx_free;
    logic [7:0] emit_byte;
    logic [31:0] rd_mux;

    always_comb begin
        unique case (state_ff)
            // [RULE1] sync byte first
            S_SYNC: emit_byte = `BPF_SYNC_BYTE;
            // [RULE2] single selector byte, no continuation
            S_GRP: emit_byte = {`BPF_SEL_MORE, groups_ff};
            // [RULE18] low byte before high byte
            S_FW_LO: emit_byte = sel_word[7:0];
            S_FW_HI: emit_byte = sel_word[15:8];
            S_PAY_SEND: emit_byte = pay_byte_ff;
            // [RULE11] checksum high byte first gives zero residue
            S_CRC_HI: emit_byte = crc_bus.crc[15:8];
            S_CRC_LO: emit_byte = crc_bus.crc[7:0];
            default: emit_byte = 8'h00;
        endcase
    end

    // [RULE10] sync and checksum bytes excluded
    assign crc_bus.clr = start_req;
    assign crc_bus.en = emit && (state_ff != S_SYNC)
        && (state_ff != S_CRC_HI) && (state_ff != S_CRC_LO);
    assign crc_bus.data = emit_byte;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (fld_hit) begin
            rd_mux = {2'h0, fmask_ff[fld_slot]};
        end else begin
            unique case (i_addr)
                `BPF_A_CTRL: rd_mux = {31'h0, busy_ff};
                `BPF_A_GROUPS: rd_mux = {25'h0, groups_ff};
                `BPF_A_STATUS: rd_mux = {16'h0, pkt_cnt_ff};
                `BPF_A_NCOUNT: rd_mux = {16'h0, n_b_ff, n_a_ff};
                `BPF_A_CRC: rd_mux = {16'h0, last_crc_ff};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            groups_ff <= `BPF_RST_GROUPS;
            n_a_ff <= `BPF_RST_N;
            n_b_ff <= `BPF_RST_N;
            for (int i = 0; i < 7; i++) begin
                fmask_ff[i] <= `BPF_RST_FMASK;
            end
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
            if (i_wr && i_addr == `BPF_A_GROUPS) begin
                groups_ff <= i_wdata[6:0];
            end
            if (i_wr && i_addr == `BPF_A_NCOUNT) begin
                n_a_ff <= i_wdata[7:0];
                n_b_ff <= i_wdata[15:8];
            end
            if (i_wr && fld_hit) begin
                fmask_ff[fld_slot] <= i_wdata[29:0];
            end
        end
    end

    // ----------------------------------------
    // Output byte slot
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            tx_byte_ff <= 8'h00;
            tx_valid_ff <= 1'b0;
            tx_last_ff <= 1'b0;
        end else if (emit) begin
            tx_byte_ff <= emit_byte;
            tx_valid_ff <= 1'b1;
            tx_last_ff <= (state_ff == S_CRC_LO);
        end else if (i_tx_ready) begin
            tx_valid_ff <= 1'b0;
            tx_last_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Packet sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state_ff <= S_IDLE;
            grp_ff <= `BPF_NONE_GRP;
            word_ff <= 1'b0;
            fld_ff <= 5'h00;
            from_ff <= 5'h00;
            size_ff <= 13'h0000;
            idx_ff <= 13'h0000;
            pay_byte_ff <= 8'h00;
            pkt_cnt_ff <= 16'h0000;
            last_crc_ff <= 16'h0000;
            pl_req_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            pl_req_ff <= 1'b0;
            unique case (state_ff)
                S_IDLE: begin
                    if (start_req) begin
                        busy_ff <= 1'b1;
                        state_ff <= S_SYNC;
                    end
                end
                S_SYNC: begin
                    if (tx_free) begin
                        state_ff <= S_GRP;
                    end
                end
                S_GRP: begin
                    if (tx_free) begin
                        grp_ff <= grp_first;
                        word_ff <= 1'b0;
                        from_ff <= 5'h00;
                        state_ff <= (grp_first == `BPF_NONE_GRP)
                            ? S_PAY_NEXT : S_FW_LO;
                    end
                end
                S_FW_LO: begin
                    if (tx_free) begin
                        state_ff <= S_FW_HI;
                    end
                end
                S_FW_HI: begin
                    if (tx_free) begin
                        if (!word_ff && more_words) begin
                            word_ff <= 1'b1;
                            state_ff <= S_FW_LO;
                        // [RULE6] next group after closing word
                        // [RULE7] one sequence per enabled group
                        end else if (grp_after != `BPF_NONE_GRP) begin
                            grp_ff <= grp_after;
                            word_ff <= 1'b0;
                            state_ff <= S_FW_LO;
                        end else begin
                            grp_ff <= grp_first;
                            from_ff <= 5'h00;
                            state_ff <= S_PAY_NEXT;
                        end
                    end
                end
                S_PAY_NEXT: begin
                    if (grp_ff == `BPF_NONE_GRP) begin
                        state_ff <= S_CRC_HI;
                    end else if (fld_next != `BPF_NONE_FLD) begin
                        fld_ff <= fld_next;
                        size_ff <= fsize(grp_ff, fld_next, cur_n);
                        idx_ff <= 13'h0000;
                        state_ff <= S_PAY_REQ;
                    end else begin
                        // [RULE8] then next higher group
                        grp_ff <= grp_after;
                        from_ff <= 5'h00;
                    end
                end
                S_PAY_REQ: begin
                    pl_req_ff <= 1'b1;
                    state_ff <= S_PAY_WAIT;
                end
                S_PAY_WAIT: begin
                    if (i_pl_valid) begin
                        pay_byte_ff <= i_pl_byte;
                        state_ff <= S_PAY_SEND;
                    end
                end
                S_PAY_SEND: begin
                    if (tx_free) begin
                        idx_ff <= idx_inc;
                        // [RULE9] next field follows directly
                        if (idx_inc == size_ff) begin
                            from_ff <= fld_ff + 5'h01;
                            state_ff <= S_PAY_NEXT;
                        end else begin
                            state_ff <= S_PAY_REQ;
                        end
                    end
                end
                S_CRC_HI: begin
                    if (tx_free) begin
                        last_crc_ff <= crc_bus.crc;
                        state_ff <= S_CRC_LO;
                    end
                end
                S_CRC_LO: begin
                    if (tx_free) begin
                        pkt_cnt_ff <= pkt_cnt_ff + 16'h0001;
                        busy_ff <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_rdata = rdata_ff;
    assign o_tx_byte = tx_byte_ff;
    assign o_tx_valid = tx_valid_ff;
    assign o_tx_last = tx_last_ff;
    assign o_pl_req = pl_req_ff;
    assign o_pl_group = grp_ff;
    assign o_pl_field = fld_ff;
    // [RULE18] index 0 is the least significant byte
    assign o_pl_index = idx_ff;
    assign o_busy = busy_ff;

endmodule : bpf_framer

// ==== bpf_framer_monitor.sv ====
// Port checker for the packet framer
`timescale 1ns/10ps
module bpf_framer_monitor (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_valid,
    input wire logic o_tx_last,
    input wire logic i_tx_ready,
    input wire logic o_pl_req,
    input wire logic [2:0] o_pl_group,
    input wire logic [4:0] o_pl_field,
    input wire logic [12:0] o_pl_index,
    input wire logic i_pl_valid,
    input wire logic [7:0] i_pl_byte,
    input wire logic o_busy
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("stalled byte changed or dropped");
    a_req_gap: assert property (o_pl_req |=> !o_pl_req [*2])
        else $error("payload requests too close");
    a_req_range: assert property (o_pl_req |->
        o_pl_group <= 3'h6 && o_pl_field <= 5'h1D)
        else $error("payload request outside group or field range");
    a_last_valid: assert property (o_tx_last |-> o_tx_valid)
        else $error("last flag without valid byte");
    a_start_busy: assert property (i_wr && i_addr == 8'h00 && i_wdata[0]
        |=> o_busy)
        else $error("start did not set busy");
    a_sync_first: assert property ($rose(o_busy) |-> ##[0:3]
        (o_tx_valid && o_tx_byte == 8'hFA))
        else $error("packet did not open with sync byte");
    a_end_idle: assert property (o_tx_last && o_tx_valid && i_tx_ready
        |-> ##[1:4] !o_busy)
        else $error("busy stayed after last byte");
    a_idle_noreq: assert property (!o_busy |-> !o_pl_req)
        else $error("payload request while idle");

    c_stall: cover property (o_tx_valid && !i_tx_ready);
    c_req: cover property (o_pl_req);
    c_end: cover property (o_tx_last && o_tx_valid && i_tx_ready);
endmodule : bpf_framer_monitor

bind bpf_framer bpf_framer_monitor i_mon (.i_clk_sys, .i_nrst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tx_byte, .o_tx_valid, .o_tx_last,
    .i_tx_ready, .o_pl_req, .o_pl_group, .o_pl_field, .o_pl_index,
    .i_pl_valid, .i_pl_byte, .o_busy);

// ==== bpf_host_rx.sv ====
// Host parser model receiving the framed byte stream
`timescale 1ns/10ps
module bpf_host_rx (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_byte,
    input wire logic i_valid,
    input wire logic i_last,
    input wire logic i_stall,
    output logic o_ready
);
    logic [7:0] got[$];
    logic [15:0] residue = 16'h0000;
    int n_pkt = 0;
    logic in_pkt_ff = 1'b0;
    logic [1:0] cnt_ff = 2'h0;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    // Stall one cycle in four when asked
    assign o_ready = !i_stall || cnt_ff != 2'h0;

    always @(posedge i_clk_sys) begin
        cnt_ff <= cnt_ff + 2'h1;
        if (!i_nrst) begin
            in_pkt_ff <= 1'b0;
        end else if (i_valid && o_ready) begin
            if (!in_pkt_ff) begin
                if (i_byte == 8'hFA) begin
                    in_pkt_ff <= 1'b1;
                    got.delete();
                    got.push_back(i_byte);
                    residue <= 16'h0000;
                end
            end else begin
                got.push_back(i_byte);
                residue <= crc_step(residue, i_byte);
                if (i_last) begin
                    in_pkt_ff <= 1'b0;
                    n_pkt <= n_pkt + 1;
                end
            end
        end
    end
endmodule : bpf_host_rx

// ==== tb.sv ====
// Self-checking bench for the packet framer
`timescale 1ns/10ps
module tb;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_pl_valid = 1'b0;
    logic [7:0] i_pl_byte = 8'h00;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [1:0] wait_ff = 2'h0;
    logic [7:0] ans_ff = 8'h00;
    wire logic [31:0] o_rdata;
    wire logic [7:0] o_tx_byte;
    wire logic o_tx_valid, o_tx_last, tx_ready, o_pl_req, o_busy;
    wire logic [2:0] o_pl_group;
    wire logic [4:0] o_pl_field;
    wire logic [12:0] o_pl_index;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    logic [20:0] req_q[$];
    logic [7:0] addrs[5] = '{8'h04, 8'h08, 8'h0C, 8'h20, 8'h40};

    always #2 i_clk_sys = ~i_clk_sys;

    bpf_framer i_dut (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .o_tx_byte, .o_tx_valid, .o_tx_last, .i_tx_ready(tx_ready),
        .o_pl_req, .o_pl_group, .o_pl_field, .o_pl_index, .i_pl_valid,
        .i_pl_byte, .o_busy);
    bpf_host_rx i_host (.i_clk_sys, .i_nrst, .i_byte(o_tx_byte),
        .i_valid(o_tx_valid), .i_last(o_tx_last), .i_stall(stall),
        .o_ready(tx_ready));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic finish_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    function automatic logic [7:0] pay(input logic [2:0] g,
                                       input logic [4:0] f,
                                       input logic [12:0] x);
        return {g, f} ^ x[7:0];
    endfunction : pay

    task automatic add_fld(input logic [2:0] g, input logic [4:0] f,
                           input int sz);
        for (int i = 0; i < sz; i++) begin
            req_q.push_back({g, f, i[12:0]});
            exp_q.push_back(pay(g, f, i[12:0]));
        end
    endtask : add_fld

    task automatic run_pkt(input int h);
        int n;
        int t;
        logic [31:0] d;
        n = i_host.n_pkt;
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h1);
        rd(8'h00, d);
        chk("busy", d[0], 1'b1);
        t = 0;
        while (i_host.n_pkt == n && t < 5000) begin
            @(posedge i_clk_sys);
            t++;
        end
        #1 chk("done", t < 5000, 1);
        chk("len", i_host.got.size(), exp_q.size() + 2);
        chk("reqs_left", req_q.size(), 0);
        for (int i = 0; i < h; i++) begin
            chk("header", i_host.got[i], exp_q[i]);
        end
        for (int i = h; i < exp_q.size(); i++) begin
            chk("payload", i_host.got[i], exp_q[i]);
        end
        chk("residue", i_host.residue, 16'h0000);
        rd(8'h10, d);
        n = i_host.got.size();
        chk("crc_reg", d, {i_host.got[n - 2], i_host.got[n - 1]});
    endtask : run_pkt

    // ----------------------------------------
    // Payload source and timeout
    // ----------------------------------------
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
        i_pl_valid <= (wait_ff == 2'h1);
        i_pl_byte <= (wait_ff == 2'h1) ? ans_ff : ~i_pl_byte;
        if (o_pl_req) begin
            chk("pl_req", {o_pl_group, o_pl_field, o_pl_index},
                req_q.size() ? req_q.pop_front() : 21'h1FFFFF);
            wait_ff <= slow ? 2'h3 : 2'h1;
            ans_ff <= pay(o_pl_group, o_pl_field, o_pl_index);
        end else if (wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        repeat (16) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        foreach (addrs[k]) begin
            rd(addrs[k], d);
            chk("reset_read", d, 32'h0);
        end
        // Groups 1 and 3, one field each
        wr(8'h04, 32'h05);
        wr(8'h20, 32'h08);
        wr(8'h28, 32'h10);
        exp_q = '{8'hFA, 8'h05, 8'h08, 8'h00, 8'h10, 8'h00};
        add_fld(3'h0, 5'h03, 12);
        add_fld(3'h2, 5'h04, 4);
        run_pkt(6);
        // Groups 4 and 7, variable fields, slow sink and source
        stall <= 1'b1;
        slow <= 1'b1;
        wr(8'h04, 32'h48);
        wr(8'h2C, 32'h0000_C000);
        wr(8'h38, 32'h0010_4008);
        wr(8'h0C, 32'h0000_0201);
        exp_q = '{8'hFA, 8'h48, 8'h00, 8'hC0, 8'h01, 8'h00, 8'h08, 8'h40};
        add_fld(3'h3, 5'h0E, 10);
        add_fld(3'h3, 5'h0F, 40);
        add_fld(3'h6, 5'h03, 1);
        add_fld(3'h6, 5'h0E, 18);
        run_pkt(8);
        rd(8'h08, d);
        chk("pkt_count", d, 32'h2);
        rd(8'h0C, d);
        chk("ncount", d, 32'h201);
        finish_test();
    end
endmodule : tb
